// ==== common/tmr2_pkg.sv ====
package tmr2_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 7;

  localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP1   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP2   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAP1   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CAP2   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SELECT = 8'h20;

  localparam int BIT_CAP2   = 7;
  localparam int BIT_CAP1   = 6;
  localparam int BIT_CAPIE  = 5;
  localparam int BIT_MAT2   = 4;
  localparam int BIT_MAT1   = 3;
  localparam int BIT_MATIE  = 2;
  localparam int BIT_WRAP   = 1;
  localparam int BIT_WRAPIE = 0;

  localparam int BIT_PORT_READ_SOURCE  = 7;
  localparam int BIT_CAPEDGE = 6;
  localparam int BIT_EVEDGE  = 5;
  localparam int PS_LSB      = 2;
  localparam int PS_W        = 3;
  localparam int MC_LSB      = 0;
  localparam int MC_W        = 2;

  localparam logic [REG_W-1:0] FLAG_BITS   = 8'hDA;
  localparam logic [REG_W-1:0] FLAGS_RST   = 8'h00;
  localparam logic [REG_W-1:0] MODE_RST    = 8'h00;
  localparam logic [REG_W-1:0] MASK_RST    = 8'hFF;
  localparam logic [CNT_W-1:0] CMP_RST     = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_MAX     = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_ONE     = 7'h01;
  localparam logic [PRE_W-1:0] PRE_ZERO    = 7'h00;

  localparam int PIN_CAP1 = 0;
  localparam int PIN_CAP2 = 1;
  localparam int PIN_EVT  = 2;
  localparam int PIN_N    = 3;

  typedef enum logic [1:0] {
    MODE_SOFT   = 2'b00,
    MODE_PWM    = 2'b01,
    MODE_CAPCMP = 2'b10,
    MODE_EVENT  = 2'b11
  } tmr2_mode_t;

endpackage

// ==== design/tmr2_ctrl.sv ====
// The implementer's own choices: the address map and the APB interface to the registers.
module tmr2_ctrl
(
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [tmr2_pkg::ADDR_W-1:0] paddr,
  input  wire logic [tmr2_pkg::DATA_W-1:0] pwdata,
  output logic      [tmr2_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       capturePinFirst,
  input  wire logic                       capturePinSecond,
  input  wire logic                       eventClockPin,
  output logic                            waveformOutPin,
  output logic                            portReadSource,
  output logic                            irq
);
  import tmr2_pkg::*;

  logic [PIN_N-1:0]  pinSync1_q;
  logic [PIN_N-1:0]  pinSync2_q;
  logic [PIN_N-1:0]  pinSync3_q;
  logic [PIN_N-1:0]  pinRise;
  logic [PIN_N-1:0]  pinFall;
  logic [REG_W-1:0]  flags_q;
  logic [REG_W-1:0]  flags_d;
  logic [REG_W-1:0]  modeReg_q;
  logic [REG_W-1:0]  modeReg_d;
  logic [REG_W-1:0]  mask_q;
  logic [REG_W-1:0]  mask_d;
  logic [CNT_W-1:0]  cmp1_q;
  logic [CNT_W-1:0]  cmp1_d;
  logic [CNT_W-1:0]  cmp2_q;
  logic [CNT_W-1:0]  cmp2_d;
  logic [CNT_W-1:0]  count_q;
  logic [CNT_W-1:0]  count_d;
  logic [CNT_W-1:0]  cap1_q;
  logic [CNT_W-1:0]  cap1_d;
  logic [CNT_W-1:0]  cap2_q;
  logic [CNT_W-1:0]  cap2_d;
  logic [PRE_W-1:0]  preCnt_q;
  logic [PRE_W-1:0]  preCnt_d;
  logic              activeSecond_q;
  logic              activeSecond_d;
  logic              wave_q;
  logic              wave_d;
  logic              irq_q;
  logic              irq_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;

  logic              wrEn;
  logic              tick;
  logic              preTick;
  logic              wrapNow;
  logic              matchNow;
  logic              capEdge1;
  logic              capEdge2;
  logic              eventEdge;
  logic [CNT_W-1:0]  countInc;
  logic [CNT_W-1:0]  activeCmp;
  logic [REG_W-1:0]  setMask;
  logic [REG_W-1:0]  clrMask;
  logic [REG_W-1:0]  gatedFlags;
  logic [PRE_W-1:0]  divMask;
  tmr2_mode_t        mode;

  // Decodes whether a bus address hits a register.
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == OFS_FLAGS) || (a == OFS_MODE) || (a == OFS_CMP1) ||
               (a == OFS_CMP2) || (a == OFS_COUNT) || (a == OFS_CAP1) ||
               (a == OFS_CAP2) || (a == OFS_MASK) || (a == OFS_SELECT);
  endfunction

  // Builds the low-bit mask whose all-ones state marks a divided tick.
  function automatic logic [PRE_W-1:0] prescaleMask(input logic [PS_W-1:0] ps);
    prescaleMask = PRE_W'((PRE_ONE << ps) - PRE_ONE);
  endfunction

  // Selects the edge polarity of a synchronised pin.
  function automatic logic pickEdge(input logic rise, input logic fall, input logic sel);
    pickEdge = sel ? rise : fall;
  endfunction

  // Pins pass two flip-flops; the third stage only feeds edge detection.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : gSync
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          pinSync1_q[gi] <= 1'b0;
          pinSync2_q[gi] <= 1'b0;
          pinSync3_q[gi] <= 1'b0;
        end
        else
        begin
          pinSync1_q[gi] <= (gi == PIN_CAP1) ? capturePinFirst :
                            (gi == PIN_CAP2) ? capturePinSecond : eventClockPin;
          pinSync2_q[gi] <= pinSync1_q[gi];
          pinSync3_q[gi] <= pinSync2_q[gi];
        end
      end
      assign pinRise[gi] = pinSync2_q[gi] & ~pinSync3_q[gi];
      assign pinFall[gi] = ~pinSync2_q[gi] & pinSync3_q[gi];
    end
  endgenerate

  always_comb
  begin
    mode      = tmr2_mode_t'(modeReg_q[MC_LSB +: MC_W]);
    wrEn      = psel && penable && pready_q && pwrite;
    capEdge1  = pickEdge(pinRise[PIN_CAP1], pinFall[PIN_CAP1], modeReg_q[BIT_CAPEDGE]);
    capEdge2  = pickEdge(pinRise[PIN_CAP2], pinFall[PIN_CAP2], modeReg_q[BIT_CAPEDGE]);
    eventEdge = pickEdge(pinRise[PIN_EVT], pinFall[PIN_EVT], modeReg_q[BIT_EVEDGE]);
    divMask   = prescaleMask(modeReg_q[PS_LSB +: PS_W]);
    preTick   = (preCnt_q & divMask) == divMask;
    preCnt_d  = preCnt_q + PRE_ONE;
    tick      = 1'b0;
    unique case (mode)
      MODE_SOFT:   tick = preTick;
      MODE_PWM:    tick = preTick;
      MODE_CAPCMP: tick = preTick;
      MODE_EVENT:  tick = eventEdge;
    endcase
    countInc  = count_q + CNT_ONE;
    activeCmp = activeSecond_q ? cmp2_q : cmp1_q;
    wrapNow   = tick && (count_q == CNT_MAX);
    matchNow  = tick && (countInc == activeCmp);
  end

  always_comb
  begin
    setMask = FLAGS_RST;
    setMask[BIT_CAP2] = (mode == MODE_CAPCMP) && capEdge2;
    setMask[BIT_CAP1] = (mode == MODE_CAPCMP) && capEdge1;
    setMask[BIT_MAT2] = matchNow && activeSecond_q;
    setMask[BIT_MAT1] = matchNow && !activeSecond_q;
    setMask[BIT_WRAP] = wrapNow;
    clrMask = (wrEn && paddr == OFS_FLAGS) ? (pwdata[REG_W-1:0] & FLAG_BITS) : FLAGS_RST;
    flags_d = (flags_q & ~clrMask) | setMask;
    if (wrEn && paddr == OFS_FLAGS)
    begin
      flags_d = (flags_d & FLAG_BITS) | (pwdata[REG_W-1:0] & ~FLAG_BITS);
    end
    modeReg_d      = (wrEn && paddr == OFS_MODE) ? pwdata[REG_W-1:0] : modeReg_q;
    mask_d         = (wrEn && paddr == OFS_MASK) ? pwdata[REG_W-1:0] : mask_q;
    cmp1_d         = (wrEn && paddr == OFS_CMP1) ? pwdata[CNT_W-1:0] : cmp1_q;
    cmp2_d         = (wrEn && paddr == OFS_CMP2) ? pwdata[CNT_W-1:0] : cmp2_q;
    activeSecond_d = (wrEn && paddr == OFS_SELECT) ? pwdata[0] : activeSecond_q;
    count_d        = tick ? countInc : count_q;
    if (wrEn && paddr == OFS_COUNT)
    begin
      count_d = pwdata[CNT_W-1:0];
    end
    cap1_d = setMask[BIT_CAP1] ? count_q : cap1_q;
    cap2_d = setMask[BIT_CAP2] ? count_q : cap2_q;
    wave_d = 1'b0;
    unique case (mode)
      MODE_SOFT:   wave_d = 1'b0;
      MODE_PWM:    wave_d = wrapNow ? 1'b1 : (matchNow ? 1'b0 : wave_q);
      MODE_CAPCMP: wave_d = matchNow ? !wave_q : wave_q;
      MODE_EVENT:  wave_d = 1'b0;
    endcase
  end

  always_comb
  begin
    gatedFlags = FLAGS_RST;
    gatedFlags[BIT_CAP2] = flags_q[BIT_CAP2] && flags_q[BIT_CAPIE];
    gatedFlags[BIT_CAP1] = flags_q[BIT_CAP1] && flags_q[BIT_CAPIE];
    gatedFlags[BIT_MAT2] = flags_q[BIT_MAT2] && flags_q[BIT_MATIE];
    gatedFlags[BIT_MAT1] = flags_q[BIT_MAT1] && flags_q[BIT_MATIE];
    gatedFlags[BIT_WRAP] = flags_q[BIT_WRAP] && flags_q[BIT_WRAPIE];
    irq_d = |(gatedFlags & mask_q);
  end

  always_comb
  begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = pready_d && !isMapped(paddr);
    prdata_d  = prdata_q;
    if (pready_d)
    begin
      prdata_d = '0;
      if (paddr == OFS_FLAGS)
      begin
        prdata_d[REG_W-1:0] = flags_q;
      end
      else if (paddr == OFS_MODE)
      begin
        prdata_d[REG_W-1:0] = modeReg_q;
      end
      else if (paddr == OFS_CMP1)
      begin
        prdata_d[CNT_W-1:0] = cmp1_q;
      end
      else if (paddr == OFS_CMP2)
      begin
        prdata_d[CNT_W-1:0] = cmp2_q;
      end
      else if (paddr == OFS_COUNT)
      begin
        prdata_d[CNT_W-1:0] = count_q;
      end
      else if (paddr == OFS_CAP1)
      begin
        prdata_d[CNT_W-1:0] = cap1_q;
      end
      else if (paddr == OFS_CAP2)
      begin
        prdata_d[CNT_W-1:0] = cap2_q;
      end
      else if (paddr == OFS_MASK)
      begin
        prdata_d[REG_W-1:0] = mask_q;
      end
      else if (paddr == OFS_SELECT)
      begin
        prdata_d[0] = activeSecond_q;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_q        <= FLAGS_RST;
      modeReg_q      <= MODE_RST;
      mask_q         <= MASK_RST;
      cmp1_q         <= CMP_RST;
      cmp2_q         <= CMP_RST;
      count_q        <= CNT_ZERO;
      cap1_q         <= CNT_ZERO;
      cap2_q         <= CNT_ZERO;
      preCnt_q       <= PRE_ZERO;
      activeSecond_q <= 1'b0;
      wave_q         <= 1'b0;
      irq_q          <= 1'b0;
      pready_q       <= 1'b0;
      pslverr_q      <= 1'b0;
      prdata_q       <= '0;
    end
    else
    begin
      flags_q        <= flags_d;
      modeReg_q      <= modeReg_d;
      mask_q         <= mask_d;
      cmp1_q         <= cmp1_d;
      cmp2_q         <= cmp2_d;
      count_q        <= count_d;
      cap1_q         <= cap1_d;
      cap2_q         <= cap2_d;
      preCnt_q       <= preCnt_d;
      activeSecond_q <= activeSecond_d;
      wave_q         <= wave_d;
      irq_q          <= irq_d;
      pready_q       <= pready_d;
      pslverr_q      <= pslverr_d;
      prdata_q       <= prdata_d;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign waveformOutPin = wave_q;
  assign portReadSource = modeReg_q[BIT_PORT_READ_SOURCE];
  assign irq            = irq_q;

  a_cap2_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    (mode == MODE_CAPCMP) && pinSync2_q[PIN_CAP2] != pinSync3_q[PIN_CAP2] &&
    pinSync2_q[PIN_CAP2] == modeReg_q[BIT_CAPEDGE] |=> flags_q[BIT_CAP2])
    else $error("Second capture flag not set after capture edge.");

  a_cap1_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    (mode == MODE_CAPCMP) && pinSync2_q[PIN_CAP1] != pinSync3_q[PIN_CAP1] &&
    pinSync2_q[PIN_CAP1] == modeReg_q[BIT_CAPEDGE] |=> flags_q[BIT_CAP1])
    else $error("First capture flag not set after capture edge.");

  a_cap_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
    flags_q[BIT_CAP2] && !(wrEn && paddr == OFS_FLAGS && pwdata[BIT_CAP2])
    |=> flags_q[BIT_CAP2])
    else $error("Second capture flag dropped without a clear.");

  a_cap_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    !flags_q[BIT_CAPIE] && !flags_q[BIT_MAT1] && !flags_q[BIT_MAT2] &&
    !flags_q[BIT_WRAP] |=> !irq_q)
    else $error("Interrupt raised with capture interrupts disabled.");

  a_match2_flag: assert property (@(posedge clk) disable iff (!nrst)
    tick && activeSecond_q && (count_q + CNT_ONE == cmp2_q) |=> flags_q[BIT_MAT2])
    else $error("Second match flag not set on match.");

  a_match1_flag: assert property (@(posedge clk) disable iff (!nrst)
    tick && !activeSecond_q && (count_q + CNT_ONE == cmp1_q) && !(wrEn && paddr == OFS_COUNT)
    |=> flags_q[BIT_MAT1] && count_q == cmp1_q)
    else $error("First match flag not set on match.");

  a_match_irq_on: assert property (@(posedge clk) disable iff (!nrst)
    flags_q[BIT_MAT1] && flags_q[BIT_MATIE] && mask_q[BIT_MAT1] |=> irq_q)
    else $error("Comparison interrupt missing.");

  a_wrap_flag: assert property (@(posedge clk) disable iff (!nrst)
    tick && count_q == CNT_MAX && !(wrEn && paddr == OFS_COUNT)
    |=> flags_q[BIT_WRAP] && count_q == CNT_ZERO)
    else $error("Wrap flag not set on counter wrap.");

  a_wrap_irq_on: assert property (@(posedge clk) disable iff (!nrst)
    flags_q[BIT_WRAP] && flags_q[BIT_WRAPIE] && mask_q[BIT_WRAP] |=> irq_q)
    else $error("Overflow interrupt missing.");

  a_port_read_src: assert property (@(posedge clk) disable iff (!nrst)
    wrEn && paddr == OFS_MODE |=> portReadSource == $past(pwdata[BIT_PORT_READ_SOURCE]))
    else $error("Port read source not updated by write.");

  a_prescale_half: assert property (@(posedge clk) disable iff (!nrst)
    mode != MODE_EVENT && modeReg_q[PS_LSB +: PS_W] == 3'h1 && !wrEn
    |-> tick == preCnt_q[0])
    else $error("Divide-by-two tick at the wrong phase.");

  a_cap1_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
    flags_q[BIT_CAP1] && !(wrEn && paddr == OFS_FLAGS && pwdata[BIT_CAP1])
    |=> flags_q[BIT_CAP1])
    else $error("First capture flag dropped without a clear.");

  a_cap_irq_on: assert property (@(posedge clk) disable iff (!nrst)
    flags_q[BIT_CAP2] && flags_q[BIT_CAPIE] && mask_q[BIT_CAP2] |=> irq_q)
    else $error("Capture interrupt missing.");

  a_match_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    !flags_q[BIT_MATIE] && !flags_q[BIT_CAPIE] && !flags_q[BIT_WRAPIE] |=> !irq_q)
    else $error("Interrupt raised with all interrupt enables clear.");
endmodule

// ==== verification/tmr2_pins.sv ====
module tmr2_pins
(
  input  wire logic clk,
  output logic      capturePinFirst,
  output logic      capturePinSecond,
  output logic      eventClockPin
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr2_pkg::*;

  initial
  begin
    capturePinFirst  = 1'b0;
    capturePinSecond = 1'b0;
    eventClockPin    = 1'b0;
  end

  // Drives one pin after an edge and holds it long enough to be seen.
  task automatic drive(input int idx, input logic lvl);
    @(posedge clk);
    case (idx)
      PIN_CAP1: capturePinFirst <= lvl;
      PIN_CAP2: capturePinSecond <= lvl;
      default:  eventClockPin <= lvl;
    endcase
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== verification/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr2_pkg::*;

  logic                clk;
  logic                nrst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata;
  logic [DATA_W-1:0]   prdata;
  logic                pready;
  logic                pslverr;
  logic                capFirst;
  logic                capSecond;
  logic                evtPin;
  logic                waveformOutPin;
  logic                portReadSource;
  logic                irq;
  logic [DATA_W-1:0]   rdData;
  logic                rdErr;
  int                  fails;
  int                  checked;

  tmr2_ctrl dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capturePinFirst(capFirst), .capturePinSecond(capSecond), .eventClockPin(evtPin),
    .waveformOutPin(waveformOutPin), .portReadSource(portReadSource), .irq(irq));

  tmr2_pins pins_u (.clk(clk), .capturePinFirst(capFirst), .capturePinSecond(capSecond),
    .eventClockPin(evtPin));

  always #2 clk = ~clk;

  task automatic end_sim();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high or 50 cycles pass.
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk({31'h0, pready}, 32'h1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rdData, exp);
  endtask

  task automatic chkIrq(input logic exp);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    end_sim();
  end

  initial
  begin
    int e;
    clk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; fails = 0; checked = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdc(OFS_FLAGS, 32'h0);
    rdc(OFS_MODE, 32'h0);
    rdc(8'h24, 32'h0);
    chk({31'h0, rdErr}, 32'h1);
    wr(OFS_CMP1, 32'h0100);
    wr(OFS_CMP2, 32'h0200);
    wr(OFS_COUNT, 32'hFFF0);
    repeat (20) @(posedge clk);
    rdc(OFS_FLAGS, 32'h02);
    chkIrq(1'b0);
    wr(OFS_FLAGS, 32'h01);
    chkIrq(1'b1);
    wr(OFS_MASK, 32'hFD);
    chkIrq(1'b0);
    wr(OFS_MASK, 32'hFF);
    wr(OFS_FLAGS, 32'h02);
    rdc(OFS_FLAGS, 32'h0);
    wr(OFS_FLAGS, 32'h04);
    wr(OFS_COUNT, 32'h00F0);
    repeat (30) @(posedge clk);
    rdc(OFS_FLAGS, 32'h0C);
    chkIrq(1'b1);
    wr(OFS_FLAGS, 32'h00);
    chkIrq(1'b0);
    wr(OFS_SELECT, 32'h1);
    wr(OFS_COUNT, 32'h01F0);
    repeat (30) @(posedge clk);
    rdc(OFS_FLAGS, 32'h18);
    wr(OFS_FLAGS, 32'h18);
    wr(OFS_SELECT, 32'h0);
    wr(OFS_COUNT, 32'h0);
    wr(OFS_MODE, 32'h5E);
    wr(OFS_FLAGS, 32'h20);
    pins_u.drive(PIN_CAP2, 1'b1);
    rdc(OFS_FLAGS, 32'hA0);
    chkIrq(1'b1);
    wr(OFS_FLAGS, 32'h80);
    pins_u.drive(PIN_CAP1, 1'b1);
    rdc(OFS_FLAGS, 32'h40);
    chkIrq(1'b0);
    wr(OFS_FLAGS, 32'h40);
    pins_u.drive(PIN_CAP1, 1'b0);
    pins_u.drive(PIN_CAP2, 1'b0);
    rdc(OFS_FLAGS, 32'h0);
    wr(OFS_MODE, 32'h1E);
    pins_u.drive(PIN_CAP1, 1'b1);
    pins_u.drive(PIN_CAP1, 1'b0);
    rdc(OFS_FLAGS, 32'h40);
    wr(OFS_FLAGS, 32'h40);
    wr(OFS_MODE, 32'h5C);
    pins_u.drive(PIN_CAP2, 1'b1);
    rdc(OFS_FLAGS, 32'h0);
    pins_u.drive(PIN_CAP2, 1'b0);
    wr(OFS_MODE, 32'h80);
    @(posedge clk);
    chk({31'h0, portReadSource}, 32'h1);
    rdc(OFS_MODE, 32'h80);
    for (int ps = 0; ps < 8; ps++)
    begin
      e = 1024 >> ps;
      wr(OFS_MODE, 32'(ps << PS_LSB));
      wr(OFS_COUNT, 32'h0);
      repeat (1024) @(posedge clk);
      apb(OFS_COUNT, 1'b0, 32'h0);
      chk({31'h0, rdData >= 32'(e) && rdData <= 32'(e + 6)}, 32'h1);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_MODE, 32'h03 | 32'(k << BIT_EVEDGE));
      wr(OFS_COUNT, 32'h0);
      pins_u.drive(PIN_EVT, 1'b1);
      rdc(OFS_COUNT, 32'(k));
      pins_u.drive(PIN_EVT, 1'b0);
      rdc(OFS_COUNT, 32'h1);
    end
    wr(OFS_MODE, 32'h01);
    wr(OFS_COUNT, 32'hFFF8);
    repeat (16) @(posedge clk);
    chk({31'h0, waveformOutPin}, 32'h1);
    end_sim();
  end
endmodule
